//--- rtl/timer_capture_unit.sv
// Capture unit with timer, prescaler and AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module timer_capture_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic capture_pin_a,
    input wire logic capture_pin_b,
    input wire logic ext_clk,
    output logic capture_pin_o,
    output logic capture_pin_oe_n,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    typedef enum {ST_IDLE, ST_RESP} wr_state_t;
    logic [7:0] control_ff;
    logic [15:0] capture_ff;
    logic [15:0] timer_ff;
    logic [3:0] presc_ff;
    logic irq_flag_ff;
    logic irq_enable_ff;
    logic [2:0] pin_cfg_ff;
    logic [2:0] tmr_cfg_ff;
    logic [1:0] div_ff;
    logic pin_prev_ff;
    logic ext_prev_ff;
    logic [7:0] awaddr_ff;
    logic aw_have_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic w_have_ff;
    wr_state_t wr_state_ff;

    logic pin_a_sync;
    logic pin_b_sync;
    logic ext_sync;
    logic pin_level;
    logic capture_mode;
    logic rise;
    logic fall;
    logic capture_event;
    logic instr_tick;
    logic ext_tick;
    logic timer_tick;
    logic write_go;
    capture_pkg::wr_req_t wreq;

    // Byte-0 merge under strobes
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] d,
                                              input logic [3:0] s);
        merge_byte = s[0] ? d[7:0] : old_v;
    endfunction

    // --------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------
    pin_sync u_sync_a (.mclk(mclk), .rst_n(rst_n), .pin_in(capture_pin_a), .pin_out(pin_a_sync));
    pin_sync u_sync_b (.mclk(mclk), .rst_n(rst_n), .pin_in(capture_pin_b), .pin_out(pin_b_sync));
    pin_sync u_sync_ext (.mclk(mclk), .rst_n(rst_n), .pin_in(ext_clk), .pin_out(ext_sync));

    // --------------------------------------------------
    // Pin selection and edge detection
    // --------------------------------------------------
    // Drive pin low-enabled when configured as output
    assign capture_pin_oe_n = ~pin_cfg_ff[capture_pkg::BIT_PIN_OUT];
    assign capture_pin_o = pin_cfg_ff[capture_pkg::BIT_PIN_LATCH];

    // Output latch feeds capture logic directly
    always_comb begin
        if (pin_cfg_ff[capture_pkg::BIT_PIN_OUT]) begin
            pin_level = pin_cfg_ff[capture_pkg::BIT_PIN_LATCH];
        end else if (pin_cfg_ff[capture_pkg::BIT_ALT_SEL]) begin
            pin_level = pin_b_sync;
        end else begin
            pin_level = pin_a_sync;
        end
    end

    // Previous pin level for edges
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_prev_ff <= 1'b0;
        end else begin
            pin_prev_ff <= pin_level;
        end
    end

    assign rise = pin_level & ~pin_prev_ff;
    assign fall = ~pin_level & pin_prev_ff;
    assign capture_mode = (control_ff[3:2] == 2'b01);

    // Event qualification per mode
    always_comb begin
        case (control_ff[3:0])
            capture_pkg::MODE_FALL: capture_event = fall;
            capture_pkg::MODE_RISE: capture_event = rise;
            capture_pkg::MODE_RISE4: capture_event = rise && presc_ff == capture_pkg::PRESC_LAST4;
            capture_pkg::MODE_RISE16:
                capture_event = rise && presc_ff == capture_pkg::PRESC_LAST16;
            default: capture_event = 1'b0;
        endcase
    end

    // --------------------------------------------------
    // Prescaler counter
    // --------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            presc_ff <= 4'h0;
        end else if (!capture_mode) begin
            presc_ff <= 4'h0;
        end else if (capture_event) begin
            presc_ff <= 4'h0;
        end else if (rise) begin
            presc_ff <= presc_ff + 4'h1;
        end
    end

    // --------------------------------------------------
    // Source timer
    // --------------------------------------------------
    // Instruction clock divider
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            div_ff <= 2'h0;
        end else if (div_ff == capture_pkg::INSTR_LAST) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end

    // External clock rising edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= ext_sync;
        end
    end

    assign instr_tick = (div_ff == capture_pkg::INSTR_LAST);
    assign ext_tick = ext_sync & ~ext_prev_ff;
    // Instruction ticks stop in sleep, external ticks continue
    always_comb begin
        if (tmr_cfg_ff[capture_pkg::BIT_TMR_EXT]) begin
            timer_tick = ext_tick;
        end else begin
            timer_tick = instr_tick & ~tmr_cfg_ff[capture_pkg::BIT_SLEEP];
        end
    end

    // Software load wins over counting
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            timer_ff <= capture_pkg::TIMER_RST;
        end else if (write_go && wreq.addr == capture_pkg::ADDR_TIMER_LOW) begin
            timer_ff[7:0] <= merge_byte(timer_ff[7:0], wreq.data, wreq.strb);
        end else if (write_go && wreq.addr == capture_pkg::ADDR_TIMER_HIGH) begin
            timer_ff[15:8] <= merge_byte(timer_ff[15:8], wreq.data, wreq.strb);
        end else if (tmr_cfg_ff[capture_pkg::BIT_TMR_ON] && timer_tick) begin
            timer_ff <= timer_ff + 16'h0001;
        end
    end

    // --------------------------------------------------
    // Capture register and flag
    // --------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            capture_ff <= 16'h0000;
        end else if (capture_event) begin
            capture_ff <= timer_ff;
        end else if (write_go && wreq.addr == capture_pkg::ADDR_VALUE_LOW) begin
            capture_ff[7:0] <= merge_byte(capture_ff[7:0], wreq.data, wreq.strb);
        end else if (write_go && wreq.addr == capture_pkg::ADDR_VALUE_HIGH) begin
            capture_ff[15:8] <= merge_byte(capture_ff[15:8], wreq.data, wreq.strb);
        end
    end

    // Set wins over clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_flag_ff <= 1'b0;
        end else if (capture_event) begin
            irq_flag_ff <= 1'b1;
        end else if (write_go && wreq.addr == capture_pkg::ADDR_IRQ_CLEAR
                     && wreq.strb[0] && wreq.data[capture_pkg::BIT_CAPTURE]) begin
            irq_flag_ff <= 1'b0;
        end
    end

    assign irq = irq_flag_ff & irq_enable_ff;

    // --------------------------------------------------
    // Configuration registers
    // --------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            control_ff <= capture_pkg::CONTROL_RST;
            irq_enable_ff <= 1'b0;
            pin_cfg_ff <= 3'h0;
            tmr_cfg_ff <= 3'h0;
        end else if (write_go) begin
            case (wreq.addr)
                capture_pkg::ADDR_CONTROL:
                    control_ff <= merge_byte(control_ff, wreq.data, wreq.strb);
                capture_pkg::ADDR_IRQ_ENABLE: begin
                    if (wreq.strb[0]) begin
                        irq_enable_ff <= wreq.data[capture_pkg::BIT_CAPTURE];
                    end
                end
                capture_pkg::ADDR_PIN_CONFIG: begin
                    if (wreq.strb[0]) begin
                        pin_cfg_ff <= wreq.data[2:0];
                    end
                end
                capture_pkg::ADDR_TIMER_CONFIG: begin
                    if (wreq.strb[0]) begin
                        tmr_cfg_ff <= wreq.data[2:0];
                    end
                end
                default: ;
            endcase
        end
    end

    // --------------------------------------------------
    // AXI4-Lite write channel
    // --------------------------------------------------
    assign s_axi_awready = ~aw_have_ff && wr_state_ff == ST_IDLE;
    assign s_axi_wready = ~w_have_ff && wr_state_ff == ST_IDLE;
    assign write_go = aw_have_ff && w_have_ff && wr_state_ff == ST_IDLE;
    assign wreq = '{addr: awaddr_ff, data: wdata_ff, strb: wstrb_ff};

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            wr_state_ff <= ST_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= capture_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            case (wr_state_ff)
                ST_IDLE: begin
                    if (write_go) begin
                        aw_have_ff <= 1'b0;
                        w_have_ff <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (awaddr_ff <= capture_pkg::ADDR_TIMER_HIGH
                                        && awaddr_ff[1:0] == 2'h0)
                                       ? capture_pkg::RESP_OKAY : capture_pkg::RESP_SLVERR;
                        wr_state_ff <= ST_RESP;
                    end
                end
                ST_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wr_state_ff <= ST_IDLE;
                    end
                end
                default: wr_state_ff <= ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------
    // AXI4-Lite read channel
    // --------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= capture_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= capture_pkg::RESP_OKAY;
            case (s_axi_araddr)
                capture_pkg::ADDR_CONTROL: s_axi_rdata <= {24'h0, control_ff};
                capture_pkg::ADDR_VALUE_LOW: s_axi_rdata <= {24'h0, capture_ff[7:0]};
                capture_pkg::ADDR_VALUE_HIGH: s_axi_rdata <= {24'h0, capture_ff[15:8]};
                capture_pkg::ADDR_STATUS: s_axi_rdata <= {31'h0, irq_flag_ff};
                capture_pkg::ADDR_IRQ_ENABLE: s_axi_rdata <= {31'h0, irq_enable_ff};
                capture_pkg::ADDR_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
                capture_pkg::ADDR_PIN_CONFIG: s_axi_rdata <= {29'h0, pin_cfg_ff};
                capture_pkg::ADDR_TIMER_CONFIG: s_axi_rdata <= {29'h0, tmr_cfg_ff};
                capture_pkg::ADDR_TIMER_LOW: s_axi_rdata <= {24'h0, timer_ff[7:0]};
                capture_pkg::ADDR_TIMER_HIGH: s_axi_rdata <= {24'h0, timer_ff[15:8]};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= capture_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // --------------------------------------------------
    // Assertions
    // --------------------------------------------------
    a_capture_copies_timer: assert property (
        @(posedge mclk) disable iff (!rst_n)
        capture_event |=> capture_ff == $past(timer_ff))
        else $error("capture value differs from timer");
    a_flag_set_capture: assert property (
        @(posedge mclk) disable iff (!rst_n)
        capture_event |=> irq_flag_ff)
        else $error("flag not set after capture");
    a_flag_stays_set: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (irq_flag_ff && !(write_go && wreq.addr == capture_pkg::ADDR_IRQ_CLEAR))
        |=> irq_flag_ff)
        else $error("flag cleared without software");
    a_presc_off_clear: assert property (
        @(posedge mclk) disable iff (!rst_n)
        !capture_mode |=> presc_ff == 4'h0)
        else $error("prescaler not cleared outside capture");
    a_rise4_fires: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (control_ff[3:0] == capture_pkg::MODE_RISE4 && capture_event)
        |-> presc_ff == capture_pkg::PRESC_LAST4 ##1 presc_ff == 4'h0)
        else $error("fourth edge prescale wrong");
    a_sleep_holds_timer: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tmr_cfg_ff[capture_pkg::BIT_SLEEP] && !tmr_cfg_ff[capture_pkg::BIT_TMR_EXT])
        |=> timer_ff == $past(timer_ff))
        else $error("timer moved during sleep");
    a_ext_sleep_counts: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (tmr_cfg_ff == 3'h7 && ext_tick) |=> timer_ff == $past(timer_ff) + 16'h0001)
        else $error("external timer stopped in sleep");
    a_pin_write_event: assert property (
        @(posedge mclk) disable iff (!rst_n)
        (pin_cfg_ff[capture_pkg::BIT_PIN_OUT] && $past(pin_cfg_ff[capture_pkg::BIT_PIN_OUT])
         && $rose(pin_cfg_ff[capture_pkg::BIT_PIN_LATCH])
         && control_ff[3:0] == capture_pkg::MODE_RISE) |-> capture_event)
        else $error("port write did not capture");
endmodule

//--- rtl/capture_pkg.sv
// Constants and types for the capture unit
package capture_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_VALUE_LOW = 8'h04;
    localparam logic [7:0] ADDR_VALUE_HIGH = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_PIN_CONFIG = 8'h18;
    localparam logic [7:0] ADDR_TIMER_CONFIG = 8'h1C;
    localparam logic [7:0] ADDR_TIMER_LOW = 8'h20;
    localparam logic [7:0] ADDR_TIMER_HIGH = 8'h24;
    // Capture mode field codes
    localparam logic [3:0] MODE_FALL = 4'h4;
    localparam logic [3:0] MODE_RISE = 4'h5;
    localparam logic [3:0] MODE_RISE4 = 4'h6;
    localparam logic [3:0] MODE_RISE16 = 4'h7;
    // Prescaler terminal counts
    localparam logic [3:0] PRESC_LAST4 = 4'h3;
    localparam logic [3:0] PRESC_LAST16 = 4'hF;
    // Instruction clock divider: mclk / 4
    localparam int INSTR_DIV = 4;
    localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    // Status/enable/clear bit positions
    localparam int BIT_CAPTURE = 0;
    // Timer configuration bit positions
    localparam int BIT_TMR_ON = 0;
    localparam int BIT_TMR_EXT = 1;
    localparam int BIT_SLEEP = 2;
    // Pin configuration bit positions
    localparam int BIT_PIN_OUT = 0;
    localparam int BIT_PIN_LATCH = 1;
    localparam int BIT_ALT_SEL = 2;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Write request carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } wr_req_t;
endpackage

//--- rtl/pin_sync.sv
// Two-stage synchroniser for external pin levels
`timescale 1ns/1ps
module pin_sync (
    mclk,
    rst_n,
    pin_in,
    pin_out
);
    input wire logic mclk;
    input wire logic rst_n;
    input wire logic pin_in;
    output logic pin_out;

    logic meta_ff;

    // Two flip-flops, first read only by second
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta_ff <= 1'b0;
            pin_out <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            pin_out <= meta_ff;
        end
    end
endmodule

//--- tb/signal_source.sv
// External signal source driving the capture pins and timer clock
`timescale 1ns/1ps
module signal_source (
    mclk,
    pin_a,
    pin_b,
    ext_clk
);
    input wire logic mclk;
    output logic pin_a;
    output logic pin_b;
    output logic ext_clk;
    // Idle levels from time zero
    initial begin
        pin_a = 1'h0;
        pin_b = 1'h0;
        ext_clk = 1'h0;
    end
    // Each level held at least 4 cycles so the synchroniser sees it
    task automatic pulses(input logic sel, input int n);
        repeat (n) begin
            @(posedge mclk);
            if (sel) pin_b <= 1'h1; else pin_a <= 1'h1;
            repeat (4) @(posedge mclk);
            if (sel) pin_b <= 1'h0; else pin_a <= 1'h0;
            repeat (4) @(posedge mclk);
        end
    endtask
    // External timer clock, still outside bursts
    task automatic ticks(input int n);
        repeat (n) begin
            repeat (4) @(posedge mclk);
            ext_clk <= 1'h1;
            repeat (4) @(posedge mclk);
            ext_clk <= 1'h0;
        end
    endtask
endmodule

//--- tb/timer_capture_unit_tb.sv
// Self-checking bench for the capture unit
`timescale 1ns/1ps
module timer_capture_unit_tb;
    typedef struct {
        logic [3:0] mode;
        logic [15:0] tval;
        int n;
        logic flag;
    } row_t;
    logic mclk, rst_n, src_a, src_b, ext_clk, pin_a, pin_o, pin_oe_n, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, lo;
    logic [1:0] bresp, rresp, rr;
    int bad_count = 0;
    int checked = 0;
    row_t rows [6];
    // Wire level of the shared pin
    assign pin_a = (pin_oe_n === 1'h0) ? pin_o : src_a;
    initial begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end
    signal_source src (.mclk(mclk), .pin_a(src_a), .pin_b(src_b), .ext_clk(ext_clk));
    timer_capture_unit uut (
        .mclk(mclk), .rst_n(rst_n), .capture_pin_a(pin_a), .capture_pin_b(src_b),
        .ext_clk(ext_clk), .capture_pin_o(pin_o), .capture_pin_oe_n(pin_oe_n), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );
    // ------------------------------------------------------------
    // Comparison and closing
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic timed_out();
        bad_count++;
        $display("MISMATCH at %0t: bus answer missing", $time);
        print_verdict();
    endtask
    // ------------------------------------------------------------
    // Register bus master
    // ------------------------------------------------------------
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1 && n < 100);
        bready <= 1'h0;
        rr = bresp;
        if (bvalid !== 1'h1) timed_out();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge mclk);
            n++;
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1 && n < 100);
        rready <= 1'h0;
        rd = rdata;
        rr = rresp;
        if (rvalid !== 1'h1) timed_out();
    endtask
    // ------------------------------------------------------------
    // Capture helpers
    // ------------------------------------------------------------
    task automatic set_timer(input logic [15:0] t);
        axi_wr(capture_pkg::ADDR_TIMER_LOW, {24'h0, t[7:0]});
        axi_wr(capture_pkg::ADDR_TIMER_HIGH, {24'h0, t[15:8]});
    endtask
    task automatic setup(input logic [3:0] m, input logic [15:0] t);
        axi_wr(capture_pkg::ADDR_CONTROL, 32'h0);
        set_timer(t);
        axi_wr(capture_pkg::ADDR_CONTROL, {28'h0, m});
        axi_wr(capture_pkg::ADDR_IRQ_CLEAR, 32'h1);
    endtask
    task automatic expect_cap(input logic f, input logic [15:0] v);
        repeat (4) @(posedge mclk);
        axi_rd(capture_pkg::ADDR_STATUS);
        check({31'h0, rd[capture_pkg::BIT_CAPTURE]}, {31'h0, f});
        if (f) begin
            axi_rd(capture_pkg::ADDR_VALUE_LOW);
            lo = rd;
            axi_rd(capture_pkg::ADDR_VALUE_HIGH);
            check({16'h0, rd[7:0], lo[7:0]}, {16'h0, v});
        end
    endtask
    task automatic do_reset();
        @(posedge mclk);
        rst_n <= 1'h0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{capture_pkg::MODE_FALL, 16'h1234, 1, 1'h1},
            '{capture_pkg::MODE_RISE, 16'hA5C3, 1, 1'h1},
            '{capture_pkg::MODE_RISE4, 16'h0F0F, 3, 1'h0},
            '{capture_pkg::MODE_RISE4, 16'h4321, 4, 1'h1},
            '{capture_pkg::MODE_RISE16, 16'hFFFF, 15, 1'h0},
            '{capture_pkg::MODE_RISE16, 16'h8001, 16, 1'h1}};
        rst_n = 1'h0;
        awvalid = 1'h0;
        wvalid = 1'h0;
        bready = 1'h0;
        arvalid = 1'h0;
        rready = 1'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'h1;
        foreach (rows[i]) begin
            setup(rows[i].mode, rows[i].tval);
            src.pulses(1'h0, rows[i].n);
            expect_cap(rows[i].flag, rows[i].tval);
            $display("row %0d done", i);
        end
        // New capture replaces an unread one
        setup(capture_pkg::MODE_RISE, 16'h1111);
        src.pulses(1'h0, 1);
        set_timer(16'h2222);
        src.pulses(1'h0, 1);
        expect_cap(1'h1, 16'h2222);
        // Level interrupt follows enable and sticky flag
        check({31'h0, irq}, 32'h0);
        axi_wr(capture_pkg::ADDR_IRQ_ENABLE, 32'h1);
        @(posedge mclk);
        check({31'h0, irq}, 32'h1);
        repeat (30) @(posedge mclk);
        expect_cap(1'h1, 16'h2222);
        axi_wr(capture_pkg::ADDR_IRQ_CLEAR, 32'h1);
        @(posedge mclk);
        check({31'h0, irq}, 32'h0);
        axi_wr(capture_pkg::ADDR_IRQ_ENABLE, 32'h0);
        $display("overwrite and interrupt done");
        // Pin driven as output, latch write makes an edge
        setup(capture_pkg::MODE_RISE, 16'h3C3C);
        axi_wr(capture_pkg::ADDR_PIN_CONFIG, 32'h1);
        check({31'h0, pin_oe_n}, 32'h0);
        axi_wr(capture_pkg::ADDR_PIN_CONFIG, 32'h3);
        expect_cap(1'h1, 16'h3C3C);
        axi_wr(capture_pkg::ADDR_PIN_CONFIG, 32'h0);
        $display("output pin done");
        // Alternate pin selection
        setup(capture_pkg::MODE_RISE, 16'h0A0A);
        axi_wr(capture_pkg::ADDR_PIN_CONFIG, 32'h4);
        src.pulses(1'h0, 1);
        expect_cap(1'h0, 16'h0A0A);
        src.pulses(1'h1, 1);
        expect_cap(1'h1, 16'h0A0A);
        axi_wr(capture_pkg::ADDR_PIN_CONFIG, 32'h0);
        $display("alternate pin done");
        // Instruction-clocked timer holds in sleep, then resumes
        axi_wr(capture_pkg::ADDR_TIMER_CONFIG, 32'h5);
        axi_rd(capture_pkg::ADDR_TIMER_LOW);
        lo = rd;
        repeat (20) @(posedge mclk);
        axi_rd(capture_pkg::ADDR_TIMER_LOW);
        check(rd, lo);
        axi_wr(capture_pkg::ADDR_TIMER_CONFIG, 32'h1);
        repeat (20) @(posedge mclk);
        axi_rd(capture_pkg::ADDR_TIMER_LOW);
        check({31'h0, rd !== lo}, 32'h1);
        // External-clocked capture keeps working in sleep
        setup(capture_pkg::MODE_RISE, 16'h0707);
        axi_wr(capture_pkg::ADDR_TIMER_CONFIG, 32'h7);
        src.ticks(3);
        src.pulses(1'h0, 1);
        repeat (4) @(posedge mclk);
        axi_rd(capture_pkg::ADDR_STATUS);
        check({31'h0, rd[capture_pkg::BIT_CAPTURE]}, 32'h1);
        axi_wr(capture_pkg::ADDR_TIMER_CONFIG, 32'h0);
        check({30'h0, rr}, {30'h0, capture_pkg::RESP_OKAY});
        $display("sleep done");
        // Unmapped address answers with an error
        axi_rd(8'h40);
        check({30'h0, rr}, {30'h0, capture_pkg::RESP_SLVERR});
        axi_wr(8'h40, 32'h0);
        check({30'h0, rr}, {30'h0, capture_pkg::RESP_SLVERR});
        // Reset in mid-count clears prescaler and registers
        setup(capture_pkg::MODE_RISE4, 16'h0055);
        src.pulses(1'h0, 2);
        do_reset();
        axi_rd(capture_pkg::ADDR_CONTROL);
        check(rd, {24'h0, capture_pkg::CONTROL_RST});
        axi_rd(capture_pkg::ADDR_TIMER_LOW);
        check(rd, {24'h0, capture_pkg::TIMER_RST[7:0]});
        check({31'h0, pin_oe_n}, 32'h1);
        axi_wr(capture_pkg::ADDR_CONTROL, {28'h0, capture_pkg::MODE_RISE4});
        axi_wr(capture_pkg::ADDR_IRQ_CLEAR, 32'h1);
        src.pulses(1'h0, 2);
        expect_cap(1'h0, 16'h0000);
        src.pulses(1'h0, 2);
        expect_cap(1'h1, capture_pkg::TIMER_RST);
        $display("reset done");
        print_verdict();
    end
endmodule
